/* File: src/pulse_tickle_pkg.sv */
/*
  Shared constants and types for the pulse command link: timing counts at the
  250 MHz core clock, state encodings and counter widths.
  Assumes both ends of the link run on the same 250 MHz clock, clk.
*/
package pulse_tickle_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 250;

  // ----------------------------------------------------------------------
  // Times in their own units and derived cycle counts
  // ----------------------------------------------------------------------
  localparam int WINDOW_US = 200;
  localparam int WINDOW_CYCLES = WINDOW_US * CLK_FREQ_MHZ;
  localparam int TICKLE_PRESET_NS = 4000;
  localparam int TICKLE_PRESET_CYCLES = (TICKLE_PRESET_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int MAX_PULSE_US = 1000;
  localparam int MAX_PULSE_CYCLES = MAX_PULSE_US * CLK_FREQ_MHZ;
  localparam int MAX_RATE_KHZ = 100;
  localparam int MIN_PERIOD_CYCLES = (1000 * CLK_FREQ_MHZ + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;

  // ----------------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------------
  localparam int CNT_W = 18;
  localparam int PERIOD_W = 24;
  typedef logic [CNT_W-1:0] count_type;
  typedef logic [PERIOD_W-1:0] period_type;

  typedef enum logic [2:0] {
    DEV_MEASURE = 3'b001,
    DEV_TICKLE = 3'b010,
    DEV_FAULT = 3'b100
  } dev_state_type;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_HIGH = 3'b010,
    CTL_LOW = 3'b100
  } ctl_state_type;

endpackage

/* File: src/pwm_link_if.sv */
/*
  The command link between a pulse command source and the laser command logic.
  Assumes one shared clock; the device still synchronises the command line.
*/
`timescale 1ns/1ps
interface pwm_link_if;

  // ----------------------------------------------------------------------
  // Link wires
  // ----------------------------------------------------------------------
  logic command;
  logic lasing_indicator;
  logic fault_detected;

  modport device (
    input command,
    output lasing_indicator,
    output fault_detected
  );

  modport controller (
    output command,
    input lasing_indicator,
    input fault_detected
  );

endinterface

/* File: src/pulse_command_source.sv */
/*
  Controller end: turns a requested period and high time into a pulse command.
  Assumes the user holds period and high time steady while run is sampled.
*/
`timescale 1ns/1ps
module pulse_command_source
  import pulse_tickle_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // User request
  input wire logic run,
  input wire logic single_shot,
  input wire period_type period_cycles,
  input wire period_type high_cycles,
  output logic busy,
  output logic fault_seen,
  // Link
  pwm_link_if.controller link
);

  // ----------------------------------------------------------------------
  // Request clamping
  // ----------------------------------------------------------------------
  localparam period_type MAX_HIGH = period_type'(MAX_PULSE_CYCLES);
  localparam period_type MIN_PERIOD = period_type'(MIN_PERIOD_CYCLES);

  ctl_state_type state;
  period_type period_q;
  period_type high_q;
  period_type count;
  logic one_shot_q;
  logic fault_meta;
  logic fault_sync;
  period_type next_period;
  period_type next_high;

  always_comb begin
    next_period = (period_cycles < MIN_PERIOD) ? MIN_PERIOD : period_cycles;
    next_high = (high_cycles > MAX_HIGH) ? MAX_HIGH : high_cycles;
    // Leave at least one low cycle per period so the line never sits at 100%.
    if (next_high >= next_period) begin
      next_high = next_period - period_type'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Pulse sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= CTL_IDLE;
      period_q <= '0;
      high_q <= '0;
      count <= '0;
      one_shot_q <= 1'b0;
      link.command <= 1'b0;
    end else if (ce) begin
      case (state)
        CTL_IDLE: begin
          count <= '0;
          if (run && next_high != '0) begin
            period_q <= next_period;
            high_q <= next_high;
            one_shot_q <= single_shot;
            link.command <= 1'b1;
            state <= CTL_HIGH;
          end
        end
        CTL_HIGH: begin
          count <= count + period_type'(1);
          if (count + period_type'(1) >= high_q) begin
            link.command <= 1'b0;
            state <= CTL_LOW;
          end
        end
        CTL_LOW: begin
          count <= count + period_type'(1);
          if (count + period_type'(1) >= period_q) begin
            count <= '0;
            // Only the requested pulses go out; no tickles are mixed in.
            if (run && !one_shot_q) begin
              link.command <= 1'b1;
              state <= CTL_HIGH;
            end else begin
              state <= CTL_IDLE;
            end
          end
        end
        default: begin
          state <= CTL_IDLE;
          link.command <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status back from the device
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else if (ce) begin
      fault_meta <= link.fault_detected;
      fault_sync <= fault_meta;
    end
  end

  assign busy = (state != CTL_IDLE);
  assign fault_seen = fault_sync;

endmodule

/* File: src/pulse_tickle_ctrl.sv */
/*
  Device end: command input logic of a pulsed laser with its own tickle
  generator and a continuous-high fault guard.
  Assumes the command line may change at any time with respect to clk, and
  that the RF stage downstream turns rf_drive straight into RF on/off.
*/
`timescale 1ns/1ps
module pulse_tickle_ctrl
  import pulse_tickle_pkg::*;
#(
  parameter int WINDOW_LEN = WINDOW_CYCLES,
  parameter int FAULT_LEN = MAX_PULSE_CYCLES
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link
  pwm_link_if.device link,
  // RF stage
  output logic rf_drive,
  output logic tickle_active
);

  // ----------------------------------------------------------------------
  // Constants at counter width
  // ----------------------------------------------------------------------
  localparam count_type WINDOW_LAST = count_type'(WINDOW_LEN - 1);
  localparam count_type FAULT_LAST = count_type'(FAULT_LEN - 1);
  localparam count_type PRESET = count_type'(TICKLE_PRESET_CYCLES);

  // ----------------------------------------------------------------------
  // Command synchroniser
  // ----------------------------------------------------------------------
  logic cmd_meta;
  logic cmd_sync;

  // The first stage feeds only the second, so a metastable sample never
  // reaches the counters below.
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_meta <= 1'b0;
      cmd_sync <= 1'b0;
    end else if (ce) begin
      cmd_meta <= link.command;
      cmd_sync <= cmd_meta;
    end
  end

  // ----------------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------------
  dev_state_type state;
  count_type window_count;
  count_type on_time;
  count_type off_time;
  count_type high_time;
  count_type tickle_left;
  logic beam_on;
  logic window_end;
  logic off_timeout;
  logic fault_hit;
  count_type next_tickle;

  // A high command drives the beam unless the fault guard has taken over.
  assign beam_on = cmd_sync && (state != DEV_FAULT);
  assign window_end = (window_count == WINDOW_LAST);
  assign off_timeout = !cmd_sync && (off_time == WINDOW_LAST);
  assign fault_hit = cmd_sync && (high_time == FAULT_LAST);

  // Topping-up length: what the window lacked to reach the preset drive.
  always_comb begin
    next_tickle = '0;
    if (on_time < PRESET) begin
      next_tickle = PRESET - on_time;
    end
  end

  // ----------------------------------------------------------------------
  // Continuous-high detection
  // ----------------------------------------------------------------------
  // A command held high past the longest legal pulse is taken as a stuck
  // line rather than a very long pulse.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_time <= '0;
    end else if (ce) begin
      if (!cmd_sync) begin
        high_time <= '0;
      end else if (high_time != FAULT_LAST) begin
        high_time <= high_time + count_type'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Off-time watchdog
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      off_time <= '0;
    end else if (ce) begin
      if (cmd_sync || state == DEV_TICKLE || off_timeout) begin
        off_time <= '0;
      end else begin
        off_time <= off_time + count_type'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Measurement window
  // ----------------------------------------------------------------------
  // The window restarts after every tickle, so the tickle itself lands once
  // per window and the idle rate is one per 204 us: the 200 us window plus the 4 us tickle.
  always_ff @(posedge clk) begin
    if (rst) begin
      window_count <= '0;
    end else if (ce) begin
      if (state != DEV_MEASURE || window_end || off_timeout) begin
        window_count <= '0;
      end else begin
        window_count <= window_count + count_type'(1);
      end
    end
  end

  // On-time saturates just above the preset: beyond that only the fact
  // that it exceeded the preset matters, and the counter stays narrow.
  always_ff @(posedge clk) begin
    if (rst) begin
      on_time <= '0;
    end else if (ce) begin
      if (state != DEV_MEASURE || window_end || off_timeout) begin
        on_time <= '0;
      end else if (beam_on && on_time <= PRESET) begin
        on_time <= on_time + count_type'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DEV_MEASURE;
      tickle_left <= '0;
    end else if (ce) begin
      case (state)
        DEV_MEASURE: begin
          if (fault_hit) begin
            state <= DEV_FAULT;
            tickle_left <= '0;
          end else if (off_timeout) begin
            // Long quiet gap: fire a full tickle even if a command follows.
            state <= DEV_TICKLE;
            tickle_left <= PRESET;
          end else if (window_end) begin
            if (next_tickle != '0) begin
              state <= DEV_TICKLE;
              tickle_left <= next_tickle;
            end else begin
              tickle_left <= '0;
            end
          end
        end
        DEV_TICKLE: begin
          if (fault_hit) begin
            state <= DEV_FAULT;
            tickle_left <= '0;
          end else if (tickle_left <= count_type'(1)) begin
            state <= DEV_MEASURE;
            tickle_left <= '0;
          end else begin
            tickle_left <= tickle_left - count_type'(1);
          end
        end
        DEV_FAULT: begin
          // No restart sequence: the first low sample resumes normal work.
          if (!cmd_sync) begin
            state <= DEV_MEASURE;
          end
        end
        default: begin
          state <= DEV_MEASURE;
          tickle_left <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // A command arriving during a tickle merges with it; the device cannot
  // know in advance that a pulse is coming.
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_drive <= 1'b0;
      tickle_active <= 1'b0;
      link.lasing_indicator <= 1'b0;
      link.fault_detected <= 1'b0;
    end else if (ce) begin
      rf_drive <= beam_on || (state == DEV_TICKLE);
      tickle_active <= (state == DEV_TICKLE);
      link.lasing_indicator <= beam_on;
      link.fault_detected <= (state == DEV_FAULT);
    end
  end

endmodule

/* File: test/pulse_tickle_properties.sv */
/*
  Checker for the command link between the source and the device ends.
  Assumes one clock, synchronous active-high reset and ce held high.
*/
`timescale 1ns/1ps
module pulse_tickle_properties
  import pulse_tickle_pkg::*;
#(
  parameter int FAULT_LEN = MAX_PULSE_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic command,
  input wire logic lasing_indicator,
  input wire logic fault_detected
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  int high_run;
  int since_rise;
  logic cmd_prev;

  always_ff @(posedge clk) begin
    if (rst || !command) begin
      high_run <= 0;
    end else begin
      high_run <= high_run + 1;
    end
  end

  // Starts saturated so that the first rise after reset is always legal.
  always_ff @(posedge clk) begin
    cmd_prev <= command;
    if (rst) begin
      since_rise <= MIN_PERIOD_CYCLES;
    end else if (command && !cmd_prev) begin
      since_rise <= 1;
    end else if (since_rise < MIN_PERIOD_CYCLES) begin
      since_rise <= since_rise + 1;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence rise_s;
    $rose(command);
  endsequence

  sequence fall_s;
    $fell(command);
  endsequence

  beam_on_a: assert property (rise_s |-> ##3 (lasing_indicator || fault_detected))
    else $error("lasing did not follow command high");
  beam_off_a: assert property (fall_s |-> ##3 !lasing_indicator)
    else $error("lasing did not end with command low");
  beam_cause_a: assert property (lasing_indicator |-> $past(command, 3))
    else $error("lasing without command high");
  fault_gate_a: assert property (fault_detected |-> !lasing_indicator)
    else $error("lasing while faulted");
  fault_onset_a: assert property ($rose(fault_detected) |-> high_run >= FAULT_LEN)
    else $error("fault raised before a long high");
  fault_clear_a: assert property (fall_s ##0 fault_detected |-> ##[1:6] !fault_detected)
    else $error("fault did not clear after command low");
  pulse_max_a: assert property (high_run <= MAX_PULSE_CYCLES)
    else $error("command pulse too long");
  rate_max_a: assert property (rise_s |-> since_rise >= MIN_PERIOD_CYCLES)
    else $error("command rate above maximum");
endmodule

/* File: test/test_pulse_command_tickle_ctrl.sv */
/*
  Bench: source and device joined on one link, plus a second device whose
  command wire the bench drives itself to force the continuous-high fault.
  Assumes the package constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
module test_pulse_command_tickle_ctrl
  import pulse_tickle_pkg::*;
;
  // ----------------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------------
  // Short window and fault counts keep the run brief.
  localparam int WIN = 2000;
  localparam int FLEN = 4000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic single_shot = 1'b0;
  period_type period_cycles = '0;
  period_type high_cycles = '0;
  logic busy, fault_seen, rf_drive, tickle_active, rf_b, tick_b;
  logic tick_seen = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;

  pwm_link_if link_a();
  pwm_link_if link_b();
  always #2 clk = ~clk;
  always @(posedge clk) if (tickle_active) tick_seen <= 1'b1;

  pulse_command_source i_pulse_command_source (.clk(clk), .rst(rst), .ce(1'b1), .run(run),
    .single_shot(single_shot), .period_cycles(period_cycles), .high_cycles(high_cycles),
    .busy(busy), .fault_seen(fault_seen), .link(link_a));
  pulse_tickle_ctrl #(.WINDOW_LEN(WIN), .FAULT_LEN(FLEN)) i_pulse_tickle_ctrl (.clk(clk),
    .rst(rst), .ce(1'b1), .link(link_a), .rf_drive(rf_drive), .tickle_active(tickle_active));
  pulse_tickle_ctrl #(.WINDOW_LEN(WIN), .FAULT_LEN(FLEN)) i_pulse_tickle_ctrl_b (.clk(clk),
    .rst(rst), .ce(1'b1), .link(link_b), .rf_drive(rf_b), .tickle_active(tick_b));
  // The two links never carry commands at the same time, so their OR lets the one checker
  // watch both the source traffic and the forced fault on the second device.
  pulse_tickle_properties #(.FAULT_LEN(FLEN)) i_pulse_tickle_properties (.clk(clk),
    .rst(rst), .command(link_a.command | link_b.command),
    .lasing_indicator(link_a.lasing_indicator | link_b.lasing_indicator),
    .fault_detected(link_a.fault_detected | link_b.fault_detected));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  always @(negedge clk) begin
    if (!rst) begin
      check("rf_drive", rf_drive, tickle_active | link_a.lasing_indicator);
      check("rf_drive b", rf_b, tick_b | link_b.lasing_indicator);
    end
  end

  function automatic logic sel(input int w);
    return (w == 0) ? tickle_active : link_a.lasing_indicator;
  endfunction

  // Waits up to lim cycles for a high level, then measures how long it stands.
  task automatic pulse_len(input int w, input int lim, output int waited, output int len);
    waited = 0;
    len = 0;
    while (sel(w) !== 1'b1 && waited < lim) begin
      @(negedge clk);
      waited++;
    end
    while (sel(w) === 1'b1 && len < lim) begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic request(input int hi, input int per, input logic one);
    @(negedge clk);
    run = 1'b1;
    single_shot = one;
    high_cycles = period_type'(hi);
    period_cycles = period_type'(per);
    @(negedge clk);
    run = ~one;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_idle();
    int w, n;
    pulse_len(0, WIN + 50, w, n);
    check("idle tickle", n, TICKLE_PRESET_CYCLES);
    check("idle wait", w > WIN - 50, 1'b1);
  endtask

  task automatic t_short();
    int w, n;
    request(40, MIN_PERIOD_CYCLES, 1'b1);
    pulse_len(1, 50, w, n);
    check("short pulse", n, 40);
    pulse_len(0, WIN + 50, w, n);
    check("top-up tickle", n, TICKLE_PRESET_CYCLES - 40);
  endtask

  task automatic t_long();
    int w, n;
    request(1200, MIN_PERIOD_CYCLES, 1'b1);
    pulse_len(0, 2 * WIN, w, n);
    check("tickle skipped", w > WIN, 1'b1);
    check("off time tickle", n, TICKLE_PRESET_CYCLES);
  endtask

  task automatic t_rate();
    int w, n;
    tick_seen = 1'b0;
    request(2000, MIN_PERIOD_CYCLES, 1'b0);
    repeat (4) begin
      pulse_len(1, MIN_PERIOD_CYCLES, w, n);
      check("rate pulse", n, 2000);
    end
    check("tickle at full rate", tick_seen, 1'b0);
    run = 1'b0;
    for (int i = 0; i < 2 * MIN_PERIOD_CYCLES && busy; i++) @(negedge clk);
    check("source idle", busy, 1'b0);
    check("source fault", fault_seen, 1'b0);
  endtask

  task automatic t_fault();
    @(negedge clk);
    link_b.command = 1'b1;
    repeat (FLEN - 10) @(negedge clk);
    check("lasing before fault", link_b.lasing_indicator, 1'b1);
    check("fault early", link_b.fault_detected, 1'b0);
    repeat (20) @(negedge clk);
    check("fault flag", link_b.fault_detected, 1'b1);
    check("fault lasing", link_b.lasing_indicator, 1'b0);
    check("fault rf", rf_b, 1'b0);
    link_b.command = 1'b0;
    repeat (6) @(negedge clk);
    check("fault clear", link_b.fault_detected, 1'b0);
    link_b.command = 1'b1;
    repeat (5) @(negedge clk);
    check("resume lasing", link_b.lasing_indicator, 1'b1);
    link_b.command = 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    link_b.command = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_idle();
    t_short();
    t_long();
    t_rate();
    t_fault();
    results();
  end

  // The scenarios need about 24000 cycles; this leaves ample margin.
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
